/* hw/bcc_clock_calendar.sv */
// Top of the BCD clock calendar: divider, counters, alarms, registers
`timescale 1ns/100ps
module bcc_clock_calendar #(
  parameter int P_DIV_W   = bcc_pkg::DIV_W,
  parameter int P_DIVISOR = bcc_pkg::DIVISOR_CYCLES
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire logic [bcc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [bcc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_write,
  input  wire logic                      i_read,
  output logic      [bcc_pkg::DATA_W-1:0] o_rdata,
  output logic                           o_interrupt,
  output logic                           o_one_second_tick
);

  localparam int NU = bcc_pkg::N_UNITS;
  localparam int NI = bcc_pkg::N_INT;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic unit_hit(input logic [7:0] addr,
                                    input logic [7:0] base,
                                    input int         idx);
    logic [7:0] offs;
    offs = 8'(idx) * bcc_pkg::ADDR_STRIDE;
    return addr == 8'(base + offs);
  endfunction

  logic wr_divisor;
  logic wr_control;
  logic wr_int_clear;
  logic wr_int_enable;

  assign wr_divisor    = i_write && (i_addr == bcc_pkg::ADDR_DIVISOR);
  assign wr_control    = i_write && (i_addr == bcc_pkg::ADDR_CONTROL);
  assign wr_int_clear  = i_write && (i_addr == bcc_pkg::ADDR_INT_CLEAR);
  assign wr_int_enable = i_write && (i_addr == bcc_pkg::ADDR_INT_ENABLE);

  ////////////////////////////////////////////////////////////////////////
  // Control and divisor registers

  logic [6:0]         control;
  logic [P_DIV_W-1:0] divisor;
  logic               soft_counter_clear_n;
  logic [NU-1:0]      test_mode;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      control <= bcc_pkg::CTRL_RESET;
    end else if (wr_control) begin
      control <= i_wdata[6:0];
    end
  end

  assign soft_counter_clear_n = control[bcc_pkg::CTRL_CLEAR_N_BIT];
  assign test_mode            = control[bcc_pkg::CTRL_TEST_LSB +: NU];

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      divisor <= P_DIV_W'(P_DIVISOR);
    end else if (wr_divisor) begin
      divisor <= i_wdata[P_DIV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-second divider

  logic [P_DIV_W-1:0] div_count;
  logic               div_end;

  // Compare with >= so a smaller divisor written mid-count still ends now
  // Divisor 0 or 1 ticks every cycle
  assign div_end = (divisor == '0) || (div_count >= (divisor - P_DIV_W'(1)));

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      div_count <= '0;
    end else if (div_end) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + P_DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_one_second_tick <= 1'b0;
    end else begin
      o_one_second_tick <= div_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time-unit counters

  logic [NU-1:0][7:0] unit_value;
  logic [NU-1:0]      unit_wrap;
  logic [NU-1:0]      unit_step;
  logic [NU-1:0]      unit_load;

  genvar gu;
  generate
    for (gu = 0; gu < NU; gu++) begin : g_unit
      logic carry_in;

      if (gu == 0) begin : g_first
        assign carry_in = o_one_second_tick;
      end else begin : g_next
        assign carry_in = unit_wrap[gu-1];
      end

      assign unit_step[gu] = test_mode[gu] ? o_one_second_tick : carry_in;
      assign unit_load[gu] = i_write && unit_hit(i_addr, bcc_pkg::ADDR_TIME0, gu);

      bcc_bcd_counter #(
        .P_FIRST (bcc_pkg::UNIT_FIRST[gu]),
        .P_LAST  (bcc_pkg::UNIT_LAST[gu])
      ) u_counter (
        .i_clk        (i_clk),
        .i_clear_n    (soft_counter_clear_n),
        .i_load       (unit_load[gu]),
        .i_load_value (i_wdata[7:0]),
        .i_step       (unit_step[gu]),
        .o_value      (unit_value[gu]),
        .o_wrap       (unit_wrap[gu])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Alarm compare and repeat

  logic [8:0]    alarm_raw [NU];
  logic [NU-1:0] match;
  logic [NU-1:0] match_q;
  logic [NU-1:0] alarm_event;
  logic [NU-1:0] repeat_event;

  generate
    for (gu = 0; gu < NU; gu++) begin : g_alm
      localparam logic IS_YEAR = (gu == bcc_pkg::U_YEAR);
      localparam logic [8:0] MASK =
        IS_YEAR ? bcc_pkg::YEAR_ALARM_MASK : bcc_pkg::ALARM_MASK;
      bcc_pkg::bcc_alarm_s fields;

      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          alarm_raw[gu] <= bcc_pkg::ALARM_RESET;
        end else if (i_write && unit_hit(i_addr, bcc_pkg::ADDR_ALARM0, gu)) begin
          alarm_raw[gu] <= i_wdata[8:0] & MASK;
        end
      end

      assign fields            = bcc_pkg::bcc_alarm_fields(alarm_raw[gu], IS_YEAR);
      assign match[gu]         = (unit_value[gu] == fields.cmp);
      assign alarm_event[gu]   = match[gu] && !match_q[gu];
      assign repeat_event[gu]  = unit_wrap[gu] && fields.repeat_en;
    end
  endgenerate

  // Edge of equality, so a held match raises one event only
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      match_q <= {NU{1'b1}};
    end else begin
      match_q <= match;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, clear and enable

  logic [NI-1:0] int_status;
  logic [NI-1:0] int_enable;
  logic [NI-1:0] int_set;
  logic [NI-1:0] int_clr;

  assign int_set = {repeat_event, alarm_event};
  assign int_clr = wr_int_clear ? i_wdata[NI-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      int_status <= bcc_pkg::INT_RESET;
    end else begin
      int_status <= (int_status & ~int_clr) | int_set;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      int_enable <= bcc_pkg::INT_RESET;
    end else if (wr_int_enable) begin
      int_enable <= i_wdata[NI-1:0];
    end
  end

  assign o_interrupt = |(int_status & int_enable);

  ////////////////////////////////////////////////////////////////////////
  // Read path

  logic [bcc_pkg::DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    case (i_addr)
      bcc_pkg::ADDR_DIVISOR: begin
        next_rdata[P_DIV_W-1:0] = divisor;
      end
      bcc_pkg::ADDR_CONTROL: begin
        next_rdata[6:0] = control;
      end
      bcc_pkg::ADDR_INT_STATUS: begin
        next_rdata[NI-1:0] = int_status;
      end
      bcc_pkg::ADDR_INT_ENABLE: begin
        next_rdata[NI-1:0] = int_enable;
      end
      bcc_pkg::ADDR_MATCH: begin
        next_rdata[NU-1:0] = match;
      end
      bcc_pkg::ADDR_DIV_PHASE: begin
        next_rdata[P_DIV_W-1:0] = div_count;
      end
      default: begin
        for (int u = 0; u < NU; u++) begin
          if (unit_hit(i_addr, bcc_pkg::ADDR_TIME0, u)) begin
            next_rdata[7:0] = unit_value[u];
          end
          if (unit_hit(i_addr, bcc_pkg::ADDR_ALARM0, u)) begin
            next_rdata[8:0] = alarm_raw[u];
          end
        end
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_read) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= '0;
    end
  end

endmodule // bcc_clock_calendar

/* hw/bcc_pkg.sv */
// Constants, register map and types of the BCD clock calendar
// Overview of operation
// - BCD counters: seconds, minutes, hours, days, months, years
// - Programmable clock divider makes one-second tick
// - Divider value rewritable while running
// - Time-unit write loads counter immediately
// - Per-unit alarm compare raises interrupt
// - Per-unit repeat alarm at terminal count
// - Seconds repeat enable is alarm bit 7
// - Test bit steps unit on second tick
// - Software control bit clears time counters
// - System reset leaves time counters untouched
// - Registers reached by simple single bus transfers
package bcc_pkg;

  localparam int          N_UNITS   = 6;
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;

  // Unit indexes
  localparam int          U_SEC     = 0;
  localparam int          U_MIN     = 1;
  localparam int          U_HOUR    = 2;
  localparam int          U_DAY     = 3;
  localparam int          U_MONTH   = 4;
  localparam int          U_YEAR    = 5;

  // Register byte addresses, one word each
  localparam logic [7:0]  ADDR_TIME0      = 8'h00;
  localparam logic [7:0]  ADDR_ALARM0     = 8'h18;
  localparam logic [7:0]  ADDR_DIVISOR    = 8'h30;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h34;
  localparam logic [7:0]  ADDR_INT_STATUS = 8'h38;
  localparam logic [7:0]  ADDR_INT_CLEAR  = 8'h3C;
  localparam logic [7:0]  ADDR_INT_ENABLE = 8'h40;
  localparam logic [7:0]  ADDR_MATCH      = 8'h44;
  localparam logic [7:0]  ADDR_DIV_PHASE  = 8'h48;
  localparam logic [7:0]  ADDR_STRIDE     = 8'h04;

  // Field positions
  localparam int          CTRL_CLEAR_N_BIT = 0;
  localparam int          CTRL_TEST_LSB    = 1;
  localparam int          REPEAT_BIT       = 7;
  localparam int          YEAR_REPEAT_BIT  = 8;
  localparam int          INT_REPEAT_LSB   = 6;
  localparam int          N_INT            = 2 * N_UNITS;

  // Values after reset, and alarm write masks
  localparam logic [6:0]  CTRL_RESET       = 7'h01;
  localparam logic [8:0]  ALARM_RESET      = 9'h000;
  localparam logic [11:0] INT_RESET        = 12'h000;
  localparam logic [8:0]  ALARM_MASK       = 9'h0FF;
  localparam logic [8:0]  YEAR_ALARM_MASK  = 9'h1FF;

  // Unit ranges, index 0 is seconds
  localparam logic [N_UNITS-1:0][7:0] UNIT_FIRST =
    {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [N_UNITS-1:0][7:0] UNIT_LAST =
    {8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'h59};

  // Tick timing
  localparam int          CLK_HZ         = 40_000_000;
  localparam int          TICK_PERIOD_S  = 1;
  localparam int          DIVISOR_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int          DIV_W          = 26;

  typedef struct packed {
    logic       repeat_en;
    logic [7:0] cmp;
  } bcc_alarm_s;

  // Splits a raw alarm register into compare value and repeat enable
  function automatic bcc_alarm_s bcc_alarm_fields(input logic [8:0] raw,
                                                  input logic       is_year);
    bcc_alarm_s f;
    if (is_year) begin
      f.repeat_en = raw[YEAR_REPEAT_BIT];
      f.cmp       = raw[7:0];
    end else begin
      f.repeat_en = raw[REPEAT_BIT];
      f.cmp       = {1'b0, raw[6:0]};
    end
    return f;
  endfunction

endpackage

/* hw/bcc_bcd_counter.sv */
// One BCD time-unit counter with load, clear and wrap carry
`timescale 1ns/100ps
module bcc_bcd_counter #(
  parameter logic [7:0] P_FIRST = 8'h00,
  parameter logic [7:0] P_LAST  = 8'h59
) (
  input  wire logic       i_clk,
  input  wire logic       i_clear_n,
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_value,
  input  wire logic       i_step,
  output logic      [7:0] o_value,
  output logic            o_wrap
);

  logic [7:0] next_value;

  // BCD increment with rollover to first value
  always_comb begin
    if (o_value == P_LAST) begin
      next_value = P_FIRST;
    end else if (o_value[3:0] == 4'h9) begin
      next_value = {o_value[7:4] + 4'h1, 4'h0};
    end else begin
      next_value = {o_value[7:4], o_value[3:0] + 4'h1};
    end
  end

  // No system reset here: only the soft clear resets the count
  always_ff @(posedge i_clk) begin
    if (!i_clear_n) begin
      o_value <= P_FIRST;
    end else if (i_load) begin
      o_value <= i_load_value;
    end else if (i_step) begin
      o_value <= next_value;
    end
  end

  assign o_wrap = i_clear_n && !i_load && i_step && (o_value == P_LAST);

endmodule // bcc_bcd_counter

/* test/bcc_bus_master.sv */
// Register bus master model for the clock calendar
`timescale 1ns/100ps
module bcc_bus_master (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  output logic      [7:0]  o_addr,
  output logic      [31:0] o_wdata,
  output logic             o_write,
  output logic             o_read
);
  initial begin
    o_addr  = 8'h00;
    o_wdata = 32'h0;
    o_write = 1'b0;
    o_read  = 1'b0;
  end
  // Called in an edge's time step; one idle edge follows each strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    o_addr  <= a;
    o_wdata <= d;
    o_write <= 1'b1;
    @(posedge i_clk);
    o_write <= 1'b0;
    @(posedge i_clk);
  endtask
  // Read data taken at the edge closing the answer cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    o_addr <= a;
    o_read <= 1'b1;
    @(posedge i_clk);
    o_read <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule // bcc_bus_master

/* test/bcc_clock_calendar_chk.sv */
// Port assertions of the BCD clock calendar
`timescale 1ns/100ps
module bcc_clock_calendar_chk #(
  parameter int P_DIV_W   = bcc_pkg::DIV_W,
  parameter int P_DIVISOR = bcc_pkg::DIVISOR_CYCLES
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_write,
  input wire logic        i_read,
  input wire logic [31:0] o_rdata,
  input wire logic        o_interrupt,
  input wire logic        o_one_second_tick
);
  localparam logic [31:0] DIV_MASK = (32'h1 << P_DIV_W) - 32'h1;
  logic [31:0] gap;
  logic [31:0] div_q;
  logic        armed;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since last tick; period unchecked until a tick follows a rewrite
  always_ff @(posedge i_clk) begin
    gap <= (!i_reset_n || o_one_second_tick) ? 32'h1 : gap + 32'h1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      div_q <= 32'(P_DIVISOR);
      armed <= 1'b0;
    end else if (i_write && i_addr == bcc_pkg::ADDR_DIVISOR) begin
      div_q <= i_wdata & DIV_MASK;
      armed <= 1'b0;
    end else if (o_one_second_tick) begin
      armed <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_rd(logic [7:0] a);
    i_write && i_addr == a ##2 i_read && i_addr == a;
  endsequence
  property p_back(logic [7:0] a, logic [31:0] m);
    s_wr_rd(a) |=> o_rdata == ($past(i_wdata, 3) & m);
  endproperty
  chk_rdata_idle: assert property (!i_read |=> o_rdata == 32'h0)
    else $error("read data outside answer cycle");
  chk_unmapped_zero: assert property (i_read && i_addr > bcc_pkg::ADDR_DIV_PHASE
    |=> o_rdata == 32'h0) else $error("unmapped read not zero");
  chk_tick_single: assert property (o_one_second_tick |=> !o_one_second_tick)
    else $error("tick longer than one cycle");
  chk_tick_period: assert property (o_one_second_tick && armed |-> gap == div_q)
    else $error("tick period differs from divisor");
  chk_div_back: assert property (p_back(bcc_pkg::ADDR_DIVISOR, DIV_MASK))
    else $error("divisor readback wrong");
  chk_ctrl_back: assert property (p_back(bcc_pkg::ADDR_CONTROL, 32'h7F))
    else $error("control readback wrong");
  chk_alarm_back: assert property (p_back(bcc_pkg::ADDR_ALARM0, 32'hFF))
    else $error("seconds alarm readback wrong");
  chk_int_masked: assert property (i_write && i_addr == bcc_pkg::ADDR_INT_ENABLE
    && i_wdata[11:0] == 12'h000 |=> !o_interrupt) else $error("masked interrupt high");
  chk_int_sticky: assert property (o_interrupt && !(i_write &&
    (i_addr == bcc_pkg::ADDR_INT_CLEAR || i_addr == bcc_pkg::ADDR_INT_ENABLE))
    |=> o_interrupt) else $error("interrupt dropped without clear");
endmodule // bcc_clock_calendar_chk
bind bcc_clock_calendar bcc_clock_calendar_chk #(.P_DIV_W(P_DIV_W), .P_DIVISOR(P_DIVISOR))
  bcc_clock_calendar_chk_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
  .o_interrupt(o_interrupt), .o_one_second_tick(o_one_second_tick));

/* test/tb_bcd_clock_calendar.sv */
// Self-checking bench of the BCD clock calendar
`timescale 1ns/100ps
module tb_bcd_clock_calendar;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } bcc_row_s;
  localparam logic [7:0] CTL = bcc_pkg::ADDR_CONTROL;
  localparam logic [7:0] CLR = bcc_pkg::ADDR_INT_CLEAR;
  localparam logic [7:0] ENA = bcc_pkg::ADDR_INT_ENABLE;
  localparam logic [7:0] AL0 = bcc_pkg::ADDR_ALARM0;
  localparam logic [7:0] DIV = bcc_pkg::ADDR_DIVISOR;
  localparam logic [7:0] T0  = bcc_pkg::ADDR_TIME0;
  localparam bcc_row_s ROWS [9] = '{'{DIV, 32'h5, 32'h5}, '{AL0, 32'h1FF, 32'hFF},
    '{AL0 + 8'h14, 32'h1FF, 32'h1FF}, '{ENA, 32'hFFF, 32'hFFF}, '{CTL, 32'hFF, 32'h7F},
    '{CTL, 32'h1, 32'h1}, '{ENA, 32'h0, 32'h0}, '{8'hFC, 32'hFFFFFFFF, 32'h0},
    '{DIV, 32'h8, 32'h8}};
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic        write, read, irq, tick;
  int          miscompares = 0;
  int          compares = 0;
  always #12.5 i_clk = ~i_clk;
  bcc_clock_calendar #(.P_DIVISOR(8)) bcc_clock_calendar_inst (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata), .i_write(write),
    .i_read(read), .o_rdata(rdata), .o_interrupt(irq), .o_one_second_tick(tick));
  bcc_bus_master bcc_bus_master_inst (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_write(write), .o_read(read));
  ////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [7:0] a, input logic [31:0] v);
    bcc_bus_master_inst.wr(a, v);
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] v);
    bcc_bus_master_inst.rd(a, v);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_hi(input int n, input bit on_tick);
    for (int k = 0; k < n && (on_tick ? tick : irq) !== 1'b1; k++) begin
      @(posedge i_clk);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 3000);
    miscompares++;
    results();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    foreach (ROWS[k]) begin
      put(ROWS[k].a, ROWS[k].d);
      get(ROWS[k].a, d);
      check(d, ROWS[k].e);
    end
    // Soft clear holds units at first value
    put(CTL, 32'h0);
    get(T0, d);
    check(d, 32'h0);
    get(T0 + 8'h0C, d);
    check(d, 32'h1);
    put(CTL, 32'h1);
    // Full carry 23:59:58 into the day, repeat alarm on seconds
    put(AL0, 32'hB0);
    put(T0 + 8'h04, 32'h59);
    put(T0 + 8'h08, 32'h23);
    // Load seconds right after a tick so no step lands before the read
    wait_hi(20, 1'b1);
    put(T0, 32'h58);
    get(T0, d);
    check(d, 32'h58);
    put(CLR, 32'hFFF);
    put(ENA, 32'h40);
    wait_hi(40, 1'b0);
    check({31'h0, irq}, 32'h1);
    get(T0 + 8'h04, d);
    check(d, 32'h0);
    get(T0 + 8'h08, d);
    check(d, 32'h0);
    get(T0 + 8'h0C, d);
    check(d, 32'h2);
    get(bcc_pkg::ADDR_INT_STATUS, d);
    check(d & 32'h40, 32'h40);
    put(ENA, 32'h0);
    check({31'h0, irq}, 32'h0);
    put(ENA, 32'h40);
    check({31'h0, irq}, 32'h1);
    put(CLR, 32'h40);
    check({31'h0, irq}, 32'h0);
    // Compare alarm on seconds reaching 05
    put(AL0, 32'h5);
    put(T0, 32'h3);
    put(CLR, 32'hFFF);
    put(ENA, 32'h1);
    wait_hi(40, 1'b0);
    check({31'h0, irq}, 32'h1);
    get(T0, d);
    check(d, 32'h5);
    get(bcc_pkg::ADDR_MATCH, d);
    check(d, 32'h7);
    // Hours stepped by one tick in test mode
    put(T0 + 8'h08, 32'h10);
    put(CTL, 32'h9);
    wait_hi(20, 1'b1);
    put(CTL, 32'h1);
    get(T0 + 8'h08, d);
    check(d, 32'h11);
    // System reset leaves the year alone
    put(T0 + 8'h14, 32'h42);
    i_reset_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    get(T0 + 8'h14, d);
    check(d, 32'h42);
    get(CTL, d);
    check(d, 32'h1);
    results();
  end
endmodule // tb_bcd_clock_calendar
